/* File: hdl/pioc_pkg.sv */
// register map, field positions and reset values for the port and interrupt-on-change block
package pioc_pkg;
  localparam int PIOC_W = 8;
  // register offsets
  localparam logic [7:0] PIOC_ADDR_DIR = 8'h00;
  localparam logic [7:0] PIOC_ADDR_IRQ_EN = 8'h02;
  localparam logic [7:0] PIOC_ADDR_DEFAULT = 8'h03;
  localparam logic [7:0] PIOC_ADDR_CMP_MODE = 8'h04;
  localparam logic [7:0] PIOC_ADDR_CONFIG = 8'h05;
  localparam logic [7:0] PIOC_ADDR_FLAGS = 8'h07;
  localparam logic [7:0] PIOC_ADDR_CAPTURE = 8'h08;
  localparam logic [7:0] PIOC_ADDR_PORT = 8'h09;
  localparam logic [7:0] PIOC_ADDR_LATCH = 8'h0a;
  // device_config field positions
  localparam int PIOC_CFG_POL_BIT = 1;
  localparam int PIOC_CFG_OD_BIT = 2;
  localparam logic [7:0] PIOC_CFG_MASK = 8'h06;
  // reset values
  localparam logic [7:0] PIOC_RST_DIR = 8'hff;
  localparam logic [7:0] PIOC_RST_ZERO = 8'h00;
endpackage : pioc_pkg

/* File: hdl/pioc_port_irq.sv */
// 8-bit port with output latch and interrupt-on-change logic
//
// Overview of operation
// - flag set only for enabled pin causing condition
// - flag one while pending, zero otherwise, reset zero
// - capture loads pin levels only at interrupt
// - capture holds until capture or port read
// - port read returns current pin levels
// - port write stores into output latch
// - latch read returns latch, not pins
// - latch drives only pins set as outputs
// - only input pins can raise interrupts
// - enable register selects participating input pins
// - compare mode picks default or previous value
// - interrupt held until qualifying read, writes ignored
// - first event captures, later ones wait clear
// - previous mode: toggle fires, new level references
// - default mode: mismatch persists regardless of reads
// - interrupt pin asserted while interrupt pending
// - mode bit one compares default, zero previous
// - open drain ignores polarity, else push-pull polarity
// - flags show further pins while pending
// - flag register writes are ignored
module pioc_port_irq (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // register access port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [pioc_pkg::PIOC_W-1:0] i_reg_wdata,
  output logic [pioc_pkg::PIOC_W-1:0] o_reg_rdata,
  // port pins
  input wire logic [pioc_pkg::PIOC_W-1:0] i_pin_in,
  output logic [pioc_pkg::PIOC_W-1:0] o_pin_out,
  output logic [pioc_pkg::PIOC_W-1:0] o_pin_oe,
  // interrupt pin
  output logic o_irq_out,
  output logic o_irq_oe
);
  import pioc_pkg::*;

  logic [PIOC_W-1:0] sync1_reg, sync2_reg, sync3_reg, pin_level_reg;
  logic [PIOC_W-1:0] dir_reg, irq_enable_reg, default_value_reg, compare_mode_reg;
  logic [PIOC_W-1:0] config_reg, output_latch_reg, irq_flags_reg, irq_capture_reg;
  logic [PIOC_W-1:0] prev_level_reg, detect;
  logic pending_reg, clear_read, raise;

  // ************************************************************
  // pin input synchroniser
  // ************************************************************
  // three stages; the level only moves once stages two and three agree
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_reg <= PIOC_RST_ZERO;
      sync2_reg <= PIOC_RST_ZERO;
      sync3_reg <= PIOC_RST_ZERO;
      pin_level_reg <= PIOC_RST_ZERO;
    end else begin
      sync1_reg <= i_pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_level_reg <= (sync2_reg & sync3_reg) | (pin_level_reg & (sync2_reg ^ sync3_reg));
    end
  end

  // ************************************************************
  // configuration and latch registers
  // ************************************************************
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      dir_reg <= PIOC_RST_DIR;
      irq_enable_reg <= PIOC_RST_ZERO;
      default_value_reg <= PIOC_RST_ZERO;
      compare_mode_reg <= PIOC_RST_ZERO;
      config_reg <= PIOC_RST_ZERO;
      output_latch_reg <= PIOC_RST_ZERO;
    end else if (i_reg_wr) begin
      // flags and capture have no write path at all
      case (i_reg_addr)
        PIOC_ADDR_DIR: dir_reg <= i_reg_wdata;
        PIOC_ADDR_IRQ_EN: irq_enable_reg <= i_reg_wdata;
        PIOC_ADDR_DEFAULT: default_value_reg <= i_reg_wdata;
        PIOC_ADDR_CMP_MODE: compare_mode_reg <= i_reg_wdata;
        PIOC_ADDR_CONFIG: config_reg <= i_reg_wdata & PIOC_CFG_MASK;
        PIOC_ADDR_PORT: output_latch_reg <= i_reg_wdata;
        PIOC_ADDR_LATCH: output_latch_reg <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  // registered; the clear from this same read lands on the same edge,
  // so the returned data is the value from before the clear
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= PIOC_RST_ZERO;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        PIOC_ADDR_DIR: o_reg_rdata <= dir_reg;
        PIOC_ADDR_IRQ_EN: o_reg_rdata <= irq_enable_reg;
        PIOC_ADDR_DEFAULT: o_reg_rdata <= default_value_reg;
        PIOC_ADDR_CMP_MODE: o_reg_rdata <= compare_mode_reg;
        PIOC_ADDR_CONFIG: o_reg_rdata <= config_reg;
        PIOC_ADDR_FLAGS: o_reg_rdata <= irq_flags_reg;
        PIOC_ADDR_CAPTURE: o_reg_rdata <= irq_capture_reg;
        PIOC_ADDR_PORT: o_reg_rdata <= pin_level_reg;
        PIOC_ADDR_LATCH: o_reg_rdata <= output_latch_reg;
        default: o_reg_rdata <= PIOC_RST_ZERO;
      endcase
    end
  end

  // ************************************************************
  // interrupt detection
  // ************************************************************
  // only reads clear; a write to capture or port leaves the interrupt alone
  assign clear_read = i_reg_rd && (i_reg_addr == PIOC_ADDR_CAPTURE ||
                                   i_reg_addr == PIOC_ADDR_PORT);
  // per pin condition: enabled input, against default or previous level
  generate
    for (genvar i = 0; i < PIOC_W; i++) begin : g_detect
      assign detect[i] = irq_enable_reg[i] && dir_reg[i] &&
        (compare_mode_reg[i] ? (pin_level_reg[i] != default_value_reg[i])
                             : (pin_level_reg[i] != prev_level_reg[i]));
    end
  endgenerate
  // a new interrupt only when none is pending or this cycle clears it
  assign raise = (|detect) && (!pending_reg || clear_read);

  // previous-level reference follows the pin, so a toggle fires once
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_level_reg <= PIOC_RST_ZERO;
    end else begin
      prev_level_reg <= pin_level_reg;
    end
  end

  // pending state; a fresh event in the clear cycle wins over the clear
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pending_reg <= 1'b0;
    end else if (raise) begin
      pending_reg <= 1'b1;
    end else if (clear_read) begin
      pending_reg <= 1'b0;
    end
  end

  // flags gather every pin with a condition, even while pending
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_flags_reg <= PIOC_RST_ZERO;
    end else if (clear_read) begin
      irq_flags_reg <= detect;
    end else begin
      irq_flags_reg <= irq_flags_reg | detect;
    end
  end

  // capture only on the first event; holds until a qualifying read
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_capture_reg <= PIOC_RST_ZERO;
    end else if (raise) begin
      irq_capture_reg <= pin_level_reg;
    end
  end

  // ************************************************************
  // pin drivers
  // ************************************************************
  // direction bit one is input, so the latch drives only outputs
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin_out <= PIOC_RST_ZERO;
      o_pin_oe <= PIOC_RST_ZERO;
    end else begin
      o_pin_out <= output_latch_reg;
      o_pin_oe <= ~dir_reg;
    end
  end

  // open drain pulls low only while pending; push-pull follows polarity
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq_out <= 1'b1;
      o_irq_oe <= 1'b1;
    end else if (config_reg[PIOC_CFG_OD_BIT]) begin
      o_irq_out <= 1'b0;
      o_irq_oe <= pending_reg;
    end else begin
      o_irq_out <= config_reg[PIOC_CFG_POL_BIT] ? pending_reg : !pending_reg;
      o_irq_oe <= 1'b1;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  // second, vector-wide statement of the pin conditions, kept apart from the generate loop
  logic [PIOC_W-1:0] chk_default, chk_prev;
  assign chk_default = irq_enable_reg & dir_reg & compare_mode_reg &
    (pin_level_reg ^ default_value_reg);
  assign chk_prev = irq_enable_reg & dir_reg & ~compare_mode_reg &
    (pin_level_reg ^ prev_level_reg);

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  // a flag bit may only rise for an enabled input pin
  flag_gate_a: assert property (##1 ((irq_flags_reg & ~$past(irq_flags_reg)) &
    ~$past(irq_enable_reg & dir_reg)) == 8'h00)
    else $error("flag set on gated pin");
  // a clearing read with no live condition empties the flags
  flag_clear_a: assert property (clear_read && !(|detect) |=> irq_flags_reg == 8'h00)
    else $error("flags not cleared");
  // the capture takes the pin levels of the raising cycle
  capture_load_a: assert property (raise |=> irq_capture_reg == $past(pin_level_reg))
    else $error("capture missed pin levels");
  // without a raise the capture never moves
  capture_hold_a: assert property (!raise |=> $stable(irq_capture_reg))
    else $error("capture changed without interrupt");
  // port reads return the synchronised pin levels
  port_read_a: assert property (i_reg_rd && i_reg_addr == PIOC_ADDR_PORT |=>
    o_reg_rdata == $past(pin_level_reg))
    else $error("port read wrong");
  // a port write lands in the latch and reaches the pins two edges on
  port_write_a: assert property (i_reg_wr && i_reg_addr == PIOC_ADDR_PORT |=> ##1
    o_pin_out == $past(i_reg_wdata, 2))
    else $error("port write lost");
  // latch reads return the latch, whatever the pins show
  latch_read_a: assert property (i_reg_rd && i_reg_addr == PIOC_ADDR_LATCH |=>
    o_reg_rdata == $past(output_latch_reg))
    else $error("latch read wrong");
  // nothing but a qualifying read drops a pending interrupt
  pending_hold_a: assert property (pending_reg && !clear_read |=> pending_reg)
    else $error("interrupt dropped early");
  // interrupt pin enable follows the drive type
  irq_pin_a: assert property (##1 o_irq_oe == ($past(config_reg[PIOC_CFG_OD_BIT]) ?
    $past(pending_reg) : 1'b1))
    else $error("interrupt pin drive wrong");
  // the clearing read still returns the captured value
  capture_read_a: assert property (i_reg_rd && i_reg_addr == PIOC_ADDR_CAPTURE |=>
    o_reg_rdata == $past(irq_capture_reg))
    else $error("capture read wrong");
  // a qualifying read with no live condition ends the interrupt
  clear_drop_a: assert property (clear_read && (chk_default | chk_prev) == 8'h00 |=>
    !pending_reg)
    else $error("interrupt not cleared by read");
  // a pin change in previous-value mode always leaves an interrupt pending
  prev_event_a: assert property ((|chk_prev) |=> pending_reg)
    else $error("pin change missed");
  // a default mismatch keeps the interrupt pending, reads or not
  default_event_a: assert property ((|chk_default) |=> pending_reg)
    else $error("default mismatch missed");
  // with no condition in either mode no interrupt appears
  no_event_a: assert property (!pending_reg &&
    (chk_default | chk_prev) == 8'h00 |=> !pending_reg)
    else $error("interrupt without condition");
  // with no enabled input pin the interrupt stays quiet
  outputs_quiet_a: assert property (!pending_reg &&
    (irq_enable_reg & dir_reg) == 8'h00 |=> !pending_reg)
    else $error("interrupt from a gated pin");
  // writes never touch the flags
  flag_write_a: assert property (i_reg_wr && !i_reg_rd &&
    (chk_default | chk_prev) == 8'h00 |=> irq_flags_reg == $past(irq_flags_reg))
    else $error("flag register changed by a write");
  // while pending, later conditions leave the capture alone
  capture_lock_a: assert property (pending_reg && !clear_read |=>
    $stable(irq_capture_reg))
    else $error("capture overwritten while pending");
  // outside a clear, flags keep old bits and gather every new condition
  flag_sticky_a: assert property (!clear_read |=>
    (irq_flags_reg & $past(irq_flags_reg | chk_default | chk_prev)) ==
    $past(irq_flags_reg | chk_default | chk_prev))
    else $error("flag dropped or missed while pending");
  // open drain only ever pulls low
  od_level_a: assert property (config_reg[PIOC_CFG_OD_BIT] |=> !o_irq_out)
    else $error("open drain drove high");
  // push-pull level is pending xnor polarity
  pp_level_a: assert property (!config_reg[PIOC_CFG_OD_BIT] |=>
    o_irq_out == ($past(config_reg[PIOC_CFG_POL_BIT]) ~^ $past(pending_reg)))
    else $error("push-pull level wrong");
  // only pins set as outputs are driven
  pin_drive_a: assert property (##1 o_pin_oe == ~$past(dir_reg))
    else $error("pin enable wrong");
  // a latch write reaches the pins two edges on
  latch_write_a: assert property (i_reg_wr && i_reg_addr == PIOC_ADDR_LATCH |=> ##1
    o_pin_out == $past(i_reg_wdata, 2))
    else $error("latch write lost");

  raise_c: cover property (!pending_reg ##1 pending_reg);
  clear_c: cover property (pending_reg && clear_read ##1 !pending_reg);
  rearm_c: cover property (clear_read && raise);
  default_mode_c: cover property (|(detect & compare_mode_reg));
  open_drain_c: cover property (config_reg[PIOC_CFG_OD_BIT] && pending_reg);

endmodule // pioc_port_irq

/* File: verification/pioc_host.sv */
// host master model that issues register reads and writes
module pioc_host (
  // clock
  input wire logic i_ref_clk,
  // register access
  output logic [7:0] o_reg_addr,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_wdata,
  input wire logic [7:0] i_reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus from time zero
  initial begin
    o_reg_addr = 8'h00;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_wdata = 8'h00;
  end
  // one strobe cycle then release, so two strobes never merge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    o_reg_addr = a;
    o_reg_wdata = d;
    o_reg_wr = 1'b1;
    @(negedge i_ref_clk);
    o_reg_wr = 1'b0;
  endtask
  // data is taken after the edge that accepted the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_ref_clk);
    o_reg_addr = a;
    o_reg_rd = 1'b1;
    @(negedge i_ref_clk);
    o_reg_rd = 1'b0;
    d = i_reg_rdata;
  endtask
endmodule // pioc_host

/* File: verification/pioc_port_irq_tb.sv */
// self-checking bench for the port and interrupt-on-change block
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module pioc_port_irq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pioc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr, wdata, rdata, ext, pout, poe, pins;
  logic wr, rd, irq_out, irq_oe;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  // ****
  // clock, pins and instances
  // ****
  always #12.5 clk = ~clk;
  // pin level: driven bits follow the latch, the rest the outside world
  assign pins = (poe & pout) | (~poe & ext);
  pioc_host host (.i_ref_clk(clk), .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_rd(rd),
    .o_reg_wdata(wdata), .i_reg_rdata(rdata));
  pioc_port_irq uut (.i_ref_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_pin_in(pins),
    .o_pin_out(pout), .o_pin_oe(poe), .o_irq_out(irq_out), .o_irq_oe(irq_oe));
  // ****
  // helpers
  // ****
  task automatic finish_test;
    if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    host.rd(a, v);
    `CHK(v, e)
  endtask
  // pin sync plus irq pipeline needs six edges; eight leaves margin
  task automatic settle;
    repeat (8) @(negedge clk);
  endtask
  // hang guard, far above the fewer than two hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      finish_test;
    end
  end
  // ****
  // main sequence
  // ****
  initial begin
    ext = 8'h00;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    `CHK({irq_oe, irq_out, poe}, 10'h300)
    rchk(PIOC_ADDR_FLAGS, 8'h00);
    rchk(PIOC_ADDR_LATCH, 8'h00);
    rchk(8'h0b, 8'h00);
    host.wr(PIOC_ADDR_DIR, 8'h0f);
    host.wr(PIOC_ADDR_PORT, 8'ha5);
    settle;
    `CHK({poe, pout}, 16'hf0a5)
    rchk(PIOC_ADDR_LATCH, 8'ha5);
    rchk(PIOC_ADDR_PORT, 8'ha0);
    // previous-value mode; pin 2 not enabled, output pins move too
    host.wr(PIOC_ADDR_IRQ_EN, 8'hfb);
    rchk(PIOC_ADDR_IRQ_EN, 8'hfb);
    host.wr(PIOC_ADDR_PORT, 8'h5a);
    ext = 8'h04;
    settle;
    `CHK(irq_out, 1'b1)
    ext = 8'h05;
    settle;
    ext = 8'h07;
    settle;
    host.wr(PIOC_ADDR_CAPTURE, 8'h00);
    host.wr(PIOC_ADDR_FLAGS, 8'hff);
    host.wr(PIOC_ADDR_PORT, 8'h5a);
    settle;
    `CHK(irq_out, 1'b0)
    rchk(PIOC_ADDR_FLAGS, 8'h03);
    rchk(PIOC_ADDR_CAPTURE, 8'h55);
    settle;
    rchk(PIOC_ADDR_FLAGS, 8'h00);
    `CHK(irq_out, 1'b1)
    // default-compare mode on pin 3 only
    host.wr(PIOC_ADDR_DEFAULT, 8'h00);
    host.wr(PIOC_ADDR_CMP_MODE, 8'h08);
    rchk(PIOC_ADDR_CMP_MODE, 8'h08);
    ext = 8'h0f;
    settle;
    rchk(PIOC_ADDR_CAPTURE, 8'h5f);
    settle;
    `CHK(irq_out, 1'b0)
    rchk(PIOC_ADDR_FLAGS, 8'h08);
    host.wr(PIOC_ADDR_CONFIG, 8'h04);
    settle;
    `CHK({irq_oe, irq_out}, 2'b10)
    host.wr(PIOC_ADDR_CONFIG, 8'h02);
    settle;
    `CHK({irq_oe, irq_out}, 2'b11)
    ext = 8'h07;
    settle;
    rchk(PIOC_ADDR_PORT, 8'h57);
    settle;
    `CHK({irq_oe, irq_out}, 2'b10)
    // open drain with nothing pending releases the pin; unused config bits drop
    host.wr(PIOC_ADDR_CONFIG, 8'hff);
    settle;
    `CHK({irq_oe, irq_out}, 2'b00)
    rchk(PIOC_ADDR_CONFIG, 8'h06);
    // latch offset write; moving output pins must not raise an interrupt
    host.wr(PIOC_ADDR_LATCH, 8'h3c);
    settle;
    `CHK({poe, pout}, 16'hf03c)
    `CHK(irq_oe, 1'b0)
    rchk(PIOC_ADDR_LATCH, 8'h3c);
    rchk(PIOC_ADDR_PORT, 8'h37);
    finish_test;
  end
endmodule // pioc_port_irq_tb
